// ===== dmaioc_pkg.sv
// Constants, field layout and state types for the DMA I/O-mode channel pair
package dmaioc_pkg;

  // Channel pair: index 0 is the A channel, index 1 the B channel
  localparam int CH_N = 2;

  // AXI4-Lite address layout: bits [5:4] pick channel or status, [3:2] the word
  localparam int AXI_AW = 6;
  localparam logic [1:0] OFS_MEM_ADDR = 2'h0;
  localparam logic [1:0] OFS_IO_ADDR = 2'h1;
  localparam logic [1:0] OFS_COUNT = 2'h2;
  localparam logic [1:0] OFS_CTRL = 2'h3;
  localparam logic [1:0] BLK_STATUS = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Control word field positions
  localparam int CTRL_W = 15;
  localparam int CTRL_XE = 0;
  localparam int CTRL_IE = 1;
  localparam int CTRL_SZ = 2;
  localparam int CTRL_MDIR = 3;
  localparam int CTRL_MSTEP = 4;
  localparam int CTRL_MODE_LSB = 5;
  localparam int CTRL_ACT_LSB = 8;
  localparam int CTRL_MXE = 11;
  localparam int CTRL_TMS = 12;
  localparam int CTRL_DSTEP = 13;
  localparam int CTRL_DDIR = 14;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;
  localparam logic [23:0] ADDR_RESET = 24'h000000;
  localparam logic [7:0] IO_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Address and counter constants
  localparam logic [15:0] IO_ADDR_HIGH = 16'hFFFF;
  localparam logic [23:0] STEP_BYTE = 24'h000001;
  localparam logic [23:0] STEP_WORD = 24'h000002;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // Activation select codes
  localparam logic [2:0] ACT_TMR0 = 3'b000;
  localparam logic [2:0] ACT_TMR1 = 3'b001;
  localparam logic [2:0] ACT_TMR2 = 3'b010;
  localparam logic [2:0] ACT_ADC = 3'b011;
  localparam logic [2:0] ACT_SER_TX = 3'b100;
  localparam logic [2:0] ACT_SER_RX = 3'b101;
  localparam logic [2:0] ACT_EXT_FALL = 3'b110;
  localparam logic [2:0] ACT_EXT_LOW = 3'b111;
  localparam logic [2:0] ACT_AUTO_BURST = 3'b000;
  localparam logic [2:0] ACT_AUTO_STEAL = 3'b010;

  // Channel modes; other codes leave the channel idle
  typedef enum logic [2:0] {
    DM_IO = 3'b000,
    DM_IDLE = 3'b001,
    DM_REPEAT = 3'b010,
    DM_NORMAL = 3'b100,
    DM_BLOCK = 3'b101
  } dmaioc_mode_e;

  // Transfer engine states
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_XFER = 1'b1
  } dmaioc_state_e;

endpackage : dmaioc_pkg

// ===== dmaioc_top.sv
// DMA channel pair: I/O, idle, repeat, normal and block modes with AXI4-Lite registers
// Functional notes
// - Block codes 000-011 pick timers, converter end
// - Block code 110 external falling edge; others unusable
// - Shared trigger serviced by fixed channel priority
// - Full address mode pairs A with B
// - I/O mode moves one item per request
// - Receive-full or converter end moves I/O to memory
// - Memory address steps once per item
// - I/O address low byte, upper bits ones
// - Counter decrements; zero clears transfer enable
// - Termination raises interrupt when enabled
// - Starting count zero means 65,536 transfers
// - I/O mode activation sources: timers, serial, converter, pin on B only
// - Idle mode keeps both addresses fixed
// - Repeat mode reloads address, count; no interrupt
// - Normal auto-request starts on setup alone
// - Cycle-steal releases bus after each item
// - Burst holds bus unless preempted
// - Block mode restores block address per block
// - Step is one for bytes, two words
// - Transfer only with both enables set
// - NMI clears master enable, suspending transfer
module dmaioc_top
  import dmaioc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] tmr_match_a,
  input wire logic ser_tx_empty,
  input wire logic ser_rx_full,
  input wire logic adc_conv_end,
  input wire logic ext_xfer_request_n,
  input wire logic nmi_event,
  input wire logic bus_preempt,
  output logic dma_bus_req,
  output logic dma_xfer_valid,
  output logic [23:0] dma_src_addr,
  output logic [23:0] dma_dst_addr,
  output logic dma_word,
  output logic dma_chan,
  input wire logic dma_xfer_ack,
  output logic [CH_N-1:0] xfer_end_irq
);

  // Activation decode, shared by both channels
  function automatic logic act_event(input logic [2:0] mode, input logic [2:0] sel,
                                     input logic is_b, input logic [7:0] ev);
    logic hit;
    hit = 1'b0;
    if (mode == DM_NORMAL)
    begin
      if (sel == ACT_AUTO_BURST || sel == ACT_AUTO_STEAL)
        hit = 1'b1;
      else if (sel == ACT_EXT_FALL || sel == ACT_EXT_LOW)
        hit = ev[sel];
    end
    else if (mode == DM_BLOCK)
    begin
      // timer A matches and converter end
      if (sel <= ACT_ADC)
        hit = ev[sel];
      // only falling edge of the pin; rest ignored
      else if (sel == ACT_EXT_FALL)
        hit = ev[sel];
    end
    else
    begin
      // short modes take every listed source; pin only on B
      if (sel <= ACT_SER_RX)
        hit = ev[sel];
      else if (sel == ACT_EXT_FALL)
        hit = is_b & ev[sel];
    end
    return hit;
  endfunction : act_event

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction : merge_strb

  logic [23:0] mem_addr [CH_N];
  logic [23:0] start_addr [CH_N];
  logic [7:0] io_low [CH_N];
  logic [15:0] count [CH_N];
  logic [15:0] start_count [CH_N];
  logic [CTRL_W-1:0] ctrl [CH_N];
  logic [CH_N-1:0] pend;
  logic [CH_N-1:0] next_pend;
  dmaioc_state_e state;
  logic cur_ch;
  logic ext_s1, ext_s2, ext_s3;
  logic ext_lvl;
  logic ext_fall;
  logic [AXI_AW-1:0] aw_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // External pin: three flops, a change counts once stages 2 and 3 agree
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
      ext_lvl <= 1'b1;
      ext_fall <= 1'b0;
    end
    else
    begin
      ext_s1 <= ext_xfer_request_n;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (ext_s2 == ext_s3)
        ext_lvl <= ext_s3;
      ext_fall <= ext_lvl & (ext_s2 == ext_s3) & ~ext_s3;
    end
  end

  logic [7:0] ev;
  assign ev = {~ext_lvl, ext_fall, ser_rx_full, ser_tx_empty, adc_conv_end, tmr_match_a};

  // Full address mode is owned by the A channel
  logic full;
  assign full = (ctrl[0][CTRL_MODE_LSB +: 3] == DM_NORMAL)
              || (ctrl[0][CTRL_MODE_LSB +: 3] == DM_BLOCK);

  logic [2:0] mode_w [CH_N];
  logic [2:0] act_w [CH_N];
  logic [CH_N-1:0] en_w;
  logic [CH_N-1:0] trig_w;
  logic [CH_N-1:0] mode_ok;

  // Per-channel enable and trigger decode
  for (genvar c = 0; c < CH_N; c++)
  begin : g_chan
    assign mode_w[c] = ctrl[c][CTRL_MODE_LSB +: 3];
    assign act_w[c] = ctrl[c][CTRL_ACT_LSB +: 3];
    // B follows A in full mode and may not run full itself
    assign mode_ok[c] = (c == 0) ? (full || mode_w[c] == DM_IO || mode_w[c] == DM_IDLE
                                    || mode_w[c] == DM_REPEAT)
                                 : (!full && (mode_w[c] == DM_IO || mode_w[c] == DM_IDLE
                                    || mode_w[c] == DM_REPEAT));
    // both enable bits must be set
    assign en_w[c] = ctrl[c][CTRL_XE] & ctrl[c][CTRL_MXE] & mode_ok[c];
    assign trig_w[c] = act_event(mode_w[c], act_w[c], 1'(c), ev);
  end

  // Granted channel: A before B
  logic grant;
  logic go;
  // fixed priority when one source starts both
  assign grant = ~(pend[0] & en_w[0]);
  assign go = |(pend & en_w);

  // Source and destination for the granted channel
  logic g_full;
  logic g_rx;
  logic [23:0] g_io;
  logic [23:0] g_src;
  logic [23:0] g_dst;
  assign g_full = (grant == 1'b0) && full;
  // receive-full and converter end move I/O to memory
  assign g_rx = (act_w[grant] == ACT_SER_RX) || (act_w[grant] == ACT_ADC);
  // fixed I/O address, upper bits all ones
  assign g_io = {IO_ADDR_HIGH, io_low[grant]};
  assign g_src = g_full ? mem_addr[0] : (g_rx ? g_io : mem_addr[grant]);
  assign g_dst = g_full ? mem_addr[1] : (g_rx ? mem_addr[grant] : g_io);

  // Current-item decode, valid while an item is on the bus
  logic [CTRL_W-1:0] cc;
  logic [2:0] cc_mode;
  logic [23:0] step;
  logic [23:0] m_step;
  logic [23:0] a_step;
  logic [23:0] b_step;
  logic [15:0] cnt_dec;
  logic cnt_last;
  logic blk_last;
  logic item_done;
  logic finish;
  logic item_end;
  logic burst;
  assign cc = ctrl[cur_ch];
  assign cc_mode = cc[CTRL_MODE_LSB +: 3];
  // one for bytes, two for words
  assign step = cc[CTRL_SZ] ? STEP_WORD : STEP_BYTE;
  // memory address steps in its set direction
  assign m_step = cc[CTRL_MDIR] ? mem_addr[cur_ch] - step : mem_addr[cur_ch] + step;
  assign a_step = !cc[CTRL_MSTEP] ? mem_addr[0]
                : (cc[CTRL_MDIR] ? mem_addr[0] - step : mem_addr[0] + step);
  assign b_step = !cc[CTRL_DSTEP] ? mem_addr[1]
                : (cc[CTRL_DDIR] ? mem_addr[1] - step : mem_addr[1] + step);
  // zero wraps to all ones, giving 65,536 items
  assign cnt_dec = count[cur_ch] - COUNT_ONE;
  assign cnt_last = (count[cur_ch] == COUNT_ONE);
  assign blk_last = (count[1] == COUNT_ONE);
  assign item_done = (state == ST_XFER) && dma_xfer_ack;
  // last item ends the run; repeat never ends
  assign finish = item_done && cnt_last && (cc_mode != DM_REPEAT)
                && ((cc_mode != DM_BLOCK) || blk_last);
  // block request stays pending until the block is done
  assign item_end = item_done && ((cc_mode != DM_BLOCK) || cnt_last);
  assign burst = (cc_mode == DM_NORMAL) && (cc[CTRL_ACT_LSB +: 3] == ACT_AUTO_BURST);

  // Pending requests; a trigger in the clearing cycle is kept
  for (genvar c = 0; c < CH_N; c++)
  begin : g_pend
    assign next_pend[c] = en_w[c] & (trig_w[c] | (pend[c] & ~(item_end && cur_ch == 1'(c))));
  end

  // Transfer engine
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      pend <= '0;
      cur_ch <= 1'b0;
      dma_xfer_valid <= 1'b0;
      dma_bus_req <= 1'b0;
      dma_src_addr <= ADDR_RESET;
      dma_dst_addr <= ADDR_RESET;
      dma_word <= 1'b0;
      dma_chan <= 1'b0;
      xfer_end_irq <= '0;
    end
    else
    begin
      pend <= next_pend;
      // pulse at termination when its enable is set
      xfer_end_irq <= '0;
      xfer_end_irq[cur_ch] <= finish & cc[CTRL_IE];
      unique case (state)
        ST_IDLE:
        begin
          dma_bus_req <= go;
          if (go)
          begin
            state <= ST_XFER;
            cur_ch <= grant;
            dma_chan <= grant;
            dma_xfer_valid <= 1'b1;
            dma_src_addr <= g_src;
            dma_dst_addr <= g_dst;
            dma_word <= ctrl[grant][CTRL_SZ];
          end
        end
        ST_XFER:
        begin
          if (dma_xfer_ack)
          begin
            state <= ST_IDLE;
            dma_xfer_valid <= 1'b0;
            // cycle-steal drops the bus after each item
            // burst keeps it unless done or preempted
            dma_bus_req <= burst & ~finish & ~bus_preempt;
          end
        end
      endcase
    end
  end

  // AXI write side decode
  logic have_aw;
  logic have_w;
  logic do_write;
  logic wr_ok;
  logic [1:0] wr_blk;
  logic [1:0] wr_idx;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  assign have_aw = ~s_axi_awready;
  assign have_w = ~s_axi_wready;
  assign do_write = have_aw & have_w & ~s_axi_bvalid;
  assign wr_blk = aw_q[5:4];
  assign wr_idx = aw_q[3:2];
  assign wr_ok = (wr_blk < BLK_STATUS) && (aw_q[1:0] == 2'b00);
  assign wr_old = (wr_idx == OFS_MEM_ADDR) ? {8'h00, mem_addr[wr_blk[0]]}
                : (wr_idx == OFS_IO_ADDR) ? {24'h000000, io_low[wr_blk[0]]}
                : (wr_idx == OFS_COUNT) ? {16'h0000, count[wr_blk[0]]}
                : {17'h00000, ctrl[wr_blk[0]]};
  assign wr_val = merge_strb(wr_old, w_data_q, w_strb_q);

  // Channel registers: engine update first, software write overrides, NMI last
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int c = 0; c < CH_N; c++)
      begin
        mem_addr[c] <= ADDR_RESET;
        start_addr[c] <= ADDR_RESET;
        io_low[c] <= IO_RESET;
        count[c] <= COUNT_RESET;
        start_count[c] <= COUNT_RESET;
        ctrl[c] <= CTRL_RESET;
      end
    end
    else
    begin
      if (item_done)
      begin
        count[cur_ch] <= cnt_dec;
        if (cc_mode == DM_IO)
          mem_addr[cur_ch] <= m_step;
        // idle mode leaves both addresses alone
        // repeat reloads address and count at the end
        if (cc_mode == DM_REPEAT)
        begin
          mem_addr[cur_ch] <= cnt_last ? start_addr[cur_ch] : m_step;
          if (cnt_last)
            count[cur_ch] <= start_count[cur_ch];
        end
        if (cc_mode == DM_NORMAL || cc_mode == DM_BLOCK)
        begin
          mem_addr[0] <= a_step;
          mem_addr[1] <= b_step;
        end
        // end of block restores the block area address
        if (cc_mode == DM_BLOCK && cnt_last)
        begin
          count[0] <= start_count[0];
          count[1] <= count[1] - COUNT_ONE;
          if (cc[CTRL_TMS])
            mem_addr[0] <= start_addr[0];
          else
            mem_addr[1] <= start_addr[1];
        end
        if (finish)
          ctrl[cur_ch][CTRL_XE] <= 1'b0;
      end
      if (do_write && wr_ok)
      begin
        unique case (wr_idx)
          OFS_MEM_ADDR:
          begin
            mem_addr[wr_blk[0]] <= wr_val[23:0];
            start_addr[wr_blk[0]] <= wr_val[23:0];
          end
          OFS_IO_ADDR: io_low[wr_blk[0]] <= wr_val[7:0];
          OFS_COUNT:
          begin
            count[wr_blk[0]] <= wr_val[15:0];
            start_count[wr_blk[0]] <= wr_val[15:0];
          end
          OFS_CTRL: ctrl[wr_blk[0]] <= wr_val[CTRL_W-1:0];
        endcase
      end
      // NMI suspends every channel; setting it again resumes
      if (nmi_event)
      begin
        for (int c = 0; c < CH_N; c++)
          ctrl[c][CTRL_MXE] <= 1'b0;
      end
    end
  end

  // AXI write handshake; address and data taken in either order
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_q <= '0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read decode; status shows engine state for software polling
  logic [1:0] rd_blk;
  logic [1:0] rd_idx;
  logic rd_ok;
  logic [31:0] rd_chan;
  logic [31:0] rd_word;
  assign rd_blk = s_axi_araddr[5:4];
  assign rd_idx = s_axi_araddr[3:2];
  assign rd_ok = (rd_blk <= BLK_STATUS) && (s_axi_araddr[1:0] == 2'b00)
               && ((rd_blk != BLK_STATUS) || (rd_idx == 2'b00));
  assign rd_chan = (rd_idx == OFS_MEM_ADDR) ? {8'h00, mem_addr[rd_blk[0]]}
                 : (rd_idx == OFS_IO_ADDR) ? {24'h000000, io_low[rd_blk[0]]}
                 : (rd_idx == OFS_COUNT) ? {16'h0000, count[rd_blk[0]]}
                 : {17'h00000, ctrl[rd_blk[0]]};
  assign rd_word = !rd_ok ? 32'h00000000
                 : (rd_blk == BLK_STATUS) ? {25'h0000000, full, cur_ch, state == ST_XFER,
                                             pend, en_w}
                 : rd_chan;

  // AXI read handshake, data one cycle after the address
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : dmaioc_top

// ===== dmaioc_bus_model.sv
// Far-side bus model answering each transfer item with an ack
module dmaioc_bus_model
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic dma_xfer_valid,
  input wire logic [1:0] ack_delay,
  output logic dma_xfer_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] wait_cnt;

  // Ack pulse after a chosen wait; slow settings stretch the item
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_cnt <= 2'h0;
      dma_xfer_ack <= 1'b0;
    end
    else
    begin
      wait_cnt <= (dma_xfer_valid && !dma_xfer_ack) ? wait_cnt + 2'h1 : 2'h0;
      dma_xfer_ack <= dma_xfer_valid && !dma_xfer_ack && (wait_cnt >= ack_delay);
    end
  end
endmodule : dmaioc_bus_model

// ===== dmaioc_top_monitor.sv
// Port checker for the DMA channel pair
module dmaioc_top_monitor
  import dmaioc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic nmi_event,
  input wire logic dma_bus_req,
  input wire logic dma_xfer_valid,
  input wire logic [23:0] dma_src_addr,
  input wire logic [23:0] dma_dst_addr,
  input wire logic dma_word,
  input wire logic dma_chan,
  input wire logic dma_xfer_ack,
  input wire logic [CH_N-1:0] xfer_end_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Register bus and transfer port timing
  AST_BRESP_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response not two cycles late");
  AST_RVALID_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle late");
  AST_AWREADY_LOW: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address accepted twice");
  AST_RDONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after handshake");
  AST_ITEM_HOLD: assert property (dma_xfer_valid && !dma_xfer_ack |=> dma_xfer_valid &&
    $stable({dma_src_addr, dma_dst_addr, dma_word, dma_chan})) else $error("item changed early");
  AST_ITEM_GAP: assert property (dma_xfer_valid && dma_xfer_ack |=> !dma_xfer_valid)
    else $error("no idle cycle between items");
  AST_REQ_COVERS: assert property (dma_xfer_valid |-> dma_bus_req)
    else $error("item without bus request");
  AST_IRQ_PULSE: assert property (xfer_end_irq[0] |=> !xfer_end_irq[0])
    else $error("end interrupt longer than a cycle");
  AST_IRQ_AT_END: assert property (xfer_end_irq[0] |->
    $past(dma_xfer_valid && dma_xfer_ack && !dma_chan)) else $error("interrupt without item");
  AST_NMI_STOP: assert property (nmi_event |-> ##2 (!$rose(dma_xfer_valid))[*3])
    else $error("item started after nmi");

  // Main scenarios reached
  COV_ITEM: cover property (dma_xfer_valid && dma_xfer_ack);
  COV_B_ITEM: cover property (dma_chan && dma_xfer_ack);
  COV_IRQ: cover property (xfer_end_irq[0]);
  COV_NMI: cover property (nmi_event);
endmodule : dmaioc_top_monitor

bind dmaioc_top dmaioc_top_monitor i_mon (.clk(clk), .resetn(resetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .nmi_event(nmi_event),
  .dma_bus_req(dma_bus_req), .dma_xfer_valid(dma_xfer_valid), .dma_src_addr(dma_src_addr),
  .dma_dst_addr(dma_dst_addr), .dma_word(dma_word), .dma_chan(dma_chan),
  .dma_xfer_ack(dma_xfer_ack), .xfer_end_irq(xfer_end_irq));

// ===== dmaioc_top_tb.sv
// Self-checking bench for the DMA channel pair
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module dmaioc_top_tb
  import dmaioc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, adc, tx, rx, ext_n, nmi, req, valid, word, chan, ack;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, delay, irq;
  logic [2:0] tmr;
  logic [23:0] src, dst;
  int fail_count = 0;
  int check_count = 0;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  logic [49:0] exp_item[$];
  logic [1:0] exp_irq[$];

  dmaioc_top i_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tmr_match_a(tmr),
    .ser_tx_empty(tx), .ser_rx_full(rx), .adc_conv_end(adc), .ext_xfer_request_n(ext_n),
    .nmi_event(nmi), .bus_preempt(1'b0), .dma_bus_req(req), .dma_xfer_valid(valid),
    .dma_src_addr(src), .dma_dst_addr(dst), .dma_word(word), .dma_chan(chan),
    .dma_xfer_ack(ack), .xfer_end_irq(irq));
  dmaioc_bus_model i_bus (.clk(clk), .resetn(resetn), .dma_xfer_valid(valid),
    .ack_delay(delay), .dma_xfer_ack(ack));

  // Clock at 100 MHz
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic tmo(input int n, input int lim);
    if (n >= lim)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask : tmo

  // Write: address and data offered together, released when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    exp_b.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    tmo(n, 50);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    exp_r.push_back({r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    tmo(n, 50);
  endtask : rd

  function automatic logic [31:0] ctl(logic ie, logic sz, logic dec, logic [2:0] act,
                                      logic mxe);
    ctl = 32'h00000001;
    ctl[CTRL_IE] = ie;
    ctl[CTRL_SZ] = sz;
    ctl[CTRL_MDIR] = dec;
    ctl[CTRL_ACT_LSB +: 3] = act;
    ctl[CTRL_MXE] = mxe;
  endfunction : ctl

  task automatic prog(input logic ch, input logic [23:0] m, input logic [7:0] io,
                      input logic [31:0] c);
    wr({1'b0, ch, 4'h0}, {8'h00, m}, RESP_OKAY);
    wr({1'b0, ch, 4'h4}, {24'h000000, io}, RESP_OKAY);
    wr({1'b0, ch, 4'h8}, 32'h00000002 >> ch, RESP_OKAY);
    wr({1'b0, ch, 4'hC}, c, RESP_OKAY);
  endtask : prog

  // One activation event of the given source code
  task automatic fire(input int code);
    @(posedge clk);
    case (code)
      0, 1, 2: tmr <= 3'(1 << code);
      3: adc <= 1'b1;
      4: tx <= 1'b1;
      5: rx <= 1'b1;
      default: ext_n <= 1'b0;
    endcase
    @(posedge clk);
    {tmr, adc, tx, rx} <= 6'h00;
    repeat (6) @(posedge clk);
    ext_n <= 1'b1;
  endtask : fire

  task automatic drain();
    int n;
    n = 0;
    while ((exp_item.size() != 0 || exp_irq.size() != 0) && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    tmo(n, 300);
    repeat (20) @(posedge clk);
  endtask : drain

  // Results against the oldest notes; unexpected results meet x
  always @(posedge clk)
  begin
    if (resetn && bvalid && bready)
      `CHK(bresp, exp_b.size() ? exp_b.pop_front() : 2'bxx)
    if (resetn && rvalid && rready)
      `CHK({rresp, rdata}, exp_r.size() ? exp_r.pop_front() : 34'bx)
    if (resetn && valid && ack)
      `CHK({chan, word, src, dst}, exp_item.size() ? exp_item.pop_front() : 50'bx)
    if (resetn && irq != 2'h0)
      `CHK(irq, exp_irq.size() ? exp_irq.pop_front() : 2'bxx)
  end

  initial
  begin
    logic [23:0] m, mk, iof;
    logic [7:0] io;
    logic sz, dec, dir_in;
    logic [31:0] c;
    {resetn, awvalid, wvalid, bready, arvalid, rready, adc, tx, rx, nmi} = 10'h000;
    {awaddr, araddr, wdata, tmr, delay} = 49'h0;
    ext_n = 1'b1;
    void'($urandom(71));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    // Reset values; unmapped and misaligned reads and status writes refused
    rd(6'h0C, {17'h0, CTRL_RESET}, RESP_OKAY);
    rd(6'h10, {8'h0, ADDR_RESET}, RESP_OKAY);
    rd(6'h18, {16'h0, COUNT_RESET}, RESP_OKAY);
    rd(6'h30, 32'h0, RESP_SLVERR);
    rd(6'h02, 32'h0, RESP_SLVERR);
    wr(6'h20, 32'h1, RESP_SLVERR);
    for (int code = 0; code < 6; code++)
    begin
      m = 24'($urandom);
      io = 8'($urandom);
      sz = code[0];
      dec = code[1];
      dir_in = (code == 3 || code == 5);
      delay <= 2'(code % 3);
      c = ctl(1'b1, sz, dec, 3'(code), 1'b1);
      prog(1'b0, m, io, c);
      mk = m;
      iof = {IO_ADDR_HIGH, io};
      for (int k = 0; k < 2; k++)
      begin
        exp_item.push_back({1'b0, sz, dir_in ? iof : mk, dir_in ? mk : iof});
        if (k == 1) exp_irq.push_back(2'b01);
        fire(code);
        drain();
        mk = dec ? mk - (sz ? STEP_WORD : STEP_BYTE) : mk + (sz ? STEP_WORD : STEP_BYTE);
      end
      rd(6'h0C, c & 32'hFFFFFFFE, RESP_OKAY);
      rd(6'h08, 32'h0, RESP_OKAY);
      rd(6'h00, {8'h00, mk}, RESP_OKAY);
      rd(6'h04, {24'h0, io}, RESP_OKAY);
    end
    prog(1'b1, 24'h000100, 8'h40, ctl(1'b0, 1'b0, 1'b0, 3'h7, 1'b1));
    for (int code = 0; code < 7; code++) fire(code);
    prog(1'b1, 24'h000100, 8'h40, ctl(1'b0, 1'b0, 1'b0, 3'h0, 1'b0));
    fire(0);
    // nmi clears master enable, resume on rewrite
    c = ctl(1'b0, 1'b1, 1'b0, 3'h6, 1'b1);
    wr(6'h1C, c, RESP_OKAY);
    @(posedge clk);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    rd(6'h1C, c & 32'hFFFFF7FF, RESP_OKAY);
    fire(6);
    drain();
    wr(6'h1C, c, RESP_OKAY);
    exp_item.push_back({2'b11, 24'h000100, IO_ADDR_HIGH, 8'h40});
    fire(6);
    drain();
    rd(6'h1C, c & 32'hFFFFFFFE, RESP_OKAY);
    prog(1'b0, 24'h000200, 8'h11, ctl(1'b0, 1'b0, 1'b0, 3'h1, 1'b1));
    prog(1'b1, 24'h000300, 8'h22, ctl(1'b0, 1'b0, 1'b0, 3'h1, 1'b1) | 32'h20);
    exp_item.push_back({2'b00, 24'h000200, IO_ADDR_HIGH, 8'h11});
    exp_item.push_back({2'b10, 24'h000300, IO_ADDR_HIGH, 8'h22});
    fire(1);
    drain();
    rd(6'h10, {8'h00, 24'h000300}, RESP_OKAY);
    report_and_stop();
  end
endmodule : dmaioc_top_tb
